// ### core/cdtu_compare.sv
// Width-parameterised signed, unsigned and inequality comparator
`timescale 1ns/100ps
`include "cdtu_defs.svh"

module cdtu_compare #(
  parameter int W = `CDTU_XLEN
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output cdtu_pkg::cdtu_cmp_t flags
);
  import cdtu_pkg::*;

  // One extra zero bit on top makes the unsigned compare exact
  wire logic [W:0] a_zx = {1'b0, a};
  wire logic [W:0] b_zx = {1'b0, b};

  // Flag generation
  assign flags.lt_signed = ($signed(a) < $signed(b));
  assign flags.lt_unsigned = (a_zx < b_zx);
  assign flags.differ = (a != b);

endmodule

// ### core/cdtu_decode.sv
// Instruction decoder for the conditional trap forms
`timescale 1ns/100ps
`include "cdtu_defs.svh"

module cdtu_decode #(
  parameter logic [5:0] FN_LT = `CDTU_FN_LT_DEF,
  parameter logic [5:0] FN_NE = `CDTU_FN_NE_DEF
) (
  input wire logic [31:0] instr,
  output cdtu_pkg::cdtu_dec_t dec
);
  import cdtu_pkg::*;

  // Field extraction; code bits 15..6 are never looked at
  wire logic [5:0] opc = instr[`CDTU_OPC_HI:`CDTU_OPC_LO];
  wire logic [5:0] fn = instr[`CDTU_FN_HI:`CDTU_FN_LO];
  wire logic [4:0] sel = instr[`CDTU_RT_HI:`CDTU_RT_LO];

  // Class opcodes hand decoding on to a second field
  wire logic is_special = (opc == `CDTU_OPC_SPECIAL);
  wire logic is_register_immediate_class = (opc == `CDTU_OPC_REGISTER_IMMEDIATE_CLASS);

  // Register forms, function field only
  wire logic hit_lt = is_special && (fn == FN_LT);
  wire logic hit_ltu = is_special && (fn == `CDTU_FN_LTU);
  wire logic hit_ne = is_special && (fn == FN_NE);

  // Immediate forms, selector in bits 20..16
  wire logic hit_lti = is_register_immediate_class && (sel == `CDTU_RT_LTI);
  wire logic hit_ltiu = is_register_immediate_class && (sel == `CDTU_RT_LTIU);
  wire logic hit_nei = is_register_immediate_class && (sel == `CDTU_RT_NEI);

  // Kind selection
  assign dec.kind = hit_lt ? KIND_LT :
                    hit_ltu ? KIND_LTU :
                    hit_ne ? KIND_NE :
                    hit_lti ? KIND_LTI :
                    hit_ltiu ? KIND_LTIU :
                    hit_nei ? KIND_NEI : KIND_NONE;
  assign dec.claimed = hit_lt | hit_ltu | hit_ne | hit_lti | hit_ltiu | hit_nei;
  assign dec.use_imm = hit_lti | hit_ltiu | hit_nei;

endmodule

// ### core/cdtu_defs.svh
// Encoding constants and field positions for the conditional trap unit
`ifndef CDTU_DEFS_SVH
`define CDTU_DEFS_SVH

// Datapath and instruction geometry
`define CDTU_XLEN 64
`define CDTU_IMM_W 16
`define CDTU_CNT_W 16

// Field positions inside the instruction word
`define CDTU_OPC_HI 31
`define CDTU_OPC_LO 26
`define CDTU_RS_HI 25
`define CDTU_RS_LO 21
`define CDTU_RT_HI 20
`define CDTU_RT_LO 16
`define CDTU_CODE_HI 15
`define CDTU_CODE_LO 6
`define CDTU_FN_HI 5
`define CDTU_FN_LO 0
`define CDTU_IMM_HI 15
`define CDTU_IMM_LO 0

// Primary opcodes of the two classes
`define CDTU_OPC_SPECIAL 6'h00
`define CDTU_OPC_REGISTER_IMMEDIATE_CLASS 6'h01

// Function codes of the register forms
`define CDTU_FN_LT_DEF 6'h32
`define CDTU_FN_LTU 6'h33
`define CDTU_FN_NE_DEF 6'h36

// Selector codes of the immediate forms
`define CDTU_RT_LTI 5'h0a
`define CDTU_RT_LTIU 5'h0b
`define CDTU_RT_NEI 5'h0e

// Reset values
`define CDTU_COUNT_RST 16'h0000

`endif

// ### core/cdtu_pkg.sv
// Types shared by the conditional trap unit files
`include "cdtu_defs.svh"

package cdtu_pkg;

  // Which trap form an instruction word names
  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_LT,
    KIND_LTU,
    KIND_NE,
    KIND_LTI,
    KIND_LTIU,
    KIND_NEI
  } cdtu_kind_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EVAL,
    ST_TRAP
  } cdtu_state_t;

  // Instruction handed over by issue, with operands already read
  typedef struct packed {
    logic [31:0] instr;
    logic [`CDTU_XLEN-1:0] pc;
    logic [`CDTU_XLEN-1:0] first_val;
    logic [`CDTU_XLEN-1:0] second_val;
  } cdtu_issue_t;

  // Decoded view of one instruction word
  typedef struct packed {
    logic claimed;
    logic use_imm;
    cdtu_kind_t kind;
  } cdtu_dec_t;

  // Comparison flags
  typedef struct packed {
    logic lt_signed;
    logic lt_unsigned;
    logic differ;
  } cdtu_cmp_t;

endpackage

// ### core/cdtu_trap_unit.sv
// Conditional trap unit: takes one issued trap instruction, raises a trap request
`timescale 1ns/100ps
`include "cdtu_defs.svh"

module cdtu_trap_unit #(
  parameter int XLEN = `CDTU_XLEN,
  parameter int CNT_W = `CDTU_CNT_W,
  parameter logic [5:0] FN_LT = `CDTU_FN_LT_DEF,
  parameter logic [5:0] FN_NE = `CDTU_FN_NE_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic issue_valid,
  input cdtu_pkg::cdtu_issue_t issue_req,
  input wire logic flush,
  input wire logic exc_ack,
  output logic issue_ready,
  output logic done,
  output logic claimed,
  output logic trap_req,
  output cdtu_pkg::cdtu_kind_t trap_kind,
  output logic [XLEN-1:0] trap_pc,
  output logic [31:0] trap_instr,
  output logic [CNT_W-1:0] trap_count
);
  import cdtu_pkg::*;

  // State and held instruction
  cdtu_state_t state_reg;
  cdtu_state_t state_next;
  cdtu_issue_t held_reg;

  // Output registers and their next values
  logic ready_reg;
  logic ready_next;
  logic done_reg;
  logic done_next;
  logic claimed_reg;
  logic claimed_next;
  logic trap_req_reg;
  logic trap_req_next;
  cdtu_kind_t kind_reg;
  logic [XLEN-1:0] pc_reg;
  logic [31:0] instr_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // Decoded word and comparison results
  cdtu_dec_t dec;
  cdtu_cmp_t flags;

  // Acceptance of a new instruction
  wire logic take = issue_valid && ready_reg && (state_reg == ST_IDLE) && !flush;

  // Sequencer phase flags
  wire logic in_eval = (state_reg == ST_EVAL);
  wire logic in_trap = (state_reg == ST_TRAP);

  // Immediate field of the held word
  wire logic [`CDTU_IMM_W-1:0] imm =
    held_reg.instr[`CDTU_IMM_HI:`CDTU_IMM_LO];

  // Sign extension before any compare; unsigned reach is thus 0..32767 or the top 32768
  wire logic [XLEN-1:0] imm_ext =
    {{(XLEN-`CDTU_IMM_W){imm[`CDTU_IMM_W-1]}}, imm};

  // Second operand: extended immediate for immediate forms, register otherwise
  wire logic [XLEN-1:0] operand_b =
    dec.use_imm ? imm_ext : held_reg.second_val;

  // Word decoder
  cdtu_decode #(
    .FN_LT(FN_LT),
    .FN_NE(FN_NE)
  ) u_decode (
    .instr(held_reg.instr),
    .dec(dec)
  );

  // Comparator on the first source value
  cdtu_compare #(
    .W(XLEN)
  ) u_compare (
    .a(held_reg.first_val),
    .b(operand_b),
    .flags(flags)
  );

  // Per-form trap conditions
  wire logic cond_lt = (dec.kind == KIND_LT) && flags.lt_signed;
  wire logic cond_ltu = (dec.kind == KIND_LTU) && flags.lt_unsigned;
  wire logic cond_ne = (dec.kind == KIND_NE) && flags.differ;
  wire logic cond_lti = (dec.kind == KIND_LTI) && flags.lt_signed;
  wire logic cond_ltiu = (dec.kind == KIND_LTIU) && flags.lt_unsigned;
  wire logic cond_nei = (dec.kind == KIND_NEI) && flags.differ;

  // Any condition true raises the trap
  wire logic trap_hit =
    cond_lt | cond_ltu | cond_ne | cond_lti | cond_ltiu | cond_nei;

  // Completion paths out of evaluation and out of the trap state
  wire logic eval_quiet = in_eval && !trap_hit;
  wire logic eval_trap = in_eval && trap_hit;
  wire logic trap_end = in_trap && exc_ack;

  // Saturating trap counter step
  wire logic count_full = &count_reg;
  wire logic count_step = eval_trap && !flush && !count_full;

  // Next state and output values
  always_comb begin
    state_next = state_reg;
    ready_next = ready_reg;
    done_next = 1'b0;
    claimed_next = claimed_reg;
    trap_req_next = trap_req_reg;
    count_next = count_reg;
    if (flush) begin
      state_next = ST_IDLE;
      ready_next = 1'b1;
      trap_req_next = 1'b0;
      claimed_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          ready_next = 1'b1;
          if (take) begin
            state_next = ST_EVAL;
            ready_next = 1'b0;
          end
        end
        ST_EVAL: begin
          claimed_next = dec.claimed;
          if (trap_hit) begin
            state_next = ST_TRAP;
            trap_req_next = 1'b1;
          end else begin
            // No register is written and no request made
            state_next = ST_IDLE;
            ready_next = 1'b1;
            done_next = 1'b1;
          end
        end
        ST_TRAP: begin
          if (exc_ack) begin
            state_next = ST_IDLE;
            ready_next = 1'b1;
            trap_req_next = 1'b0;
            done_next = 1'b1;
          end
        end
      endcase
    end
    if (count_step) begin
      count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Sequencer state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Capture of the issued instruction and its operands
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      held_reg <= '0;
    end else if (clk_en && take) begin
      held_reg <= issue_req;
    end
  end

  // Handshake and completion flags
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      claimed_reg <= 1'b0;
    end else if (clk_en) begin
      ready_reg <= ready_next;
      done_reg <= done_next;
      claimed_reg <= claimed_next;
    end
  end

  // Trap request, held until the exception logic accepts it or a flush drops it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      trap_req_reg <= 1'b0;
    end else if (clk_en) begin
      trap_req_reg <= trap_req_next;
    end
  end

  // Trap details for the exception logic, loaded when a trap is raised
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      kind_reg <= KIND_NONE;
      pc_reg <= '0;
      instr_reg <= 32'h0000_0000;
    end else if (clk_en && eval_trap && !flush) begin
      kind_reg <= dec.kind;
      pc_reg <= held_reg.pc;
      instr_reg <= held_reg.instr;
    end
  end

  // Count of traps raised, saturating
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= `CDTU_COUNT_RST;
    end else if (clk_en) begin
      count_reg <= count_next;
    end
  end

  // Outputs straight from flip-flops
  assign issue_ready = ready_reg;
  assign done = done_reg;
  assign claimed = claimed_reg;
  assign trap_req = trap_req_reg;
  assign trap_kind = kind_reg;
  assign trap_pc = pc_reg;
  assign trap_instr = instr_reg;
  assign trap_count = count_reg;

endmodule

// ### tb/cdtu_exc_model.sv
// Exception logic stand-in that acknowledges trap requests
`timescale 1ns/100ps
module cdtu_exc_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic trap_req,
  input wire logic [3:0] ack_delay,
  output logic exc_ack
);
  logic [3:0] wait_reg;

  // Wait ack_delay cycles on a pending request, then pulse the ack
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= 4'h0;
      exc_ack <= 1'b0;
    end else if (trap_req && !exc_ack && wait_reg < ack_delay) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      wait_reg <= 4'h0;
      exc_ack <= trap_req && !exc_ack;
    end
  end
endmodule

// ### tb/cdtu_trap_checker_assertions.sv
// Checker of trap decode, comparison and handshake timing
`timescale 1ns/100ps
module cdtu_trap_checker
  import cdtu_pkg::*;
#(
  parameter int XLEN = 64,
  parameter logic [5:0] FN_LT = 6'h32,
  parameter logic [5:0] FN_NE = 6'h36
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic issue_valid,
  input cdtu_pkg::cdtu_issue_t issue_req,
  input wire logic flush,
  input wire logic exc_ack,
  input wire logic issue_ready,
  input wire logic done,
  input wire logic trap_req,
  input cdtu_pkg::cdtu_kind_t trap_kind,
  input wire logic [31:0] trap_instr
);
  // Fields and operands of the offered word
  wire [31:0] w = issue_req.instr;
  wire [XLEN-1:0] a = issue_req.first_val;
  wire [XLEN-1:0] b = issue_req.second_val;
  wire [XLEN-1:0] imm = {{(XLEN-16){w[15]}}, w[15:0]};
  wire [5:0] fn = w[5:0];
  wire [4:0] sel = w[20:16];
  wire sp = w[31:26] == 6'h00;
  wire ri = w[31:26] == 6'h01;
  wire take = clk_en && issue_valid && issue_ready && !flush;
  wire ok = clk_en && !flush;
  wire hit_r = fn == FN_LT && $signed(a) < $signed(b) || fn == 6'h33 && a < b
    || fn == FN_NE && a != b;
  wire hit_i = sel == 5'h0a && $signed(a) < $signed(imm) || sel == 5'h0b && a < imm
    || sel == 5'h0e && a != imm;
  wire hit = sp && hit_r || ri && hit_i;

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_lt;
    take && sp && fn == FN_LT && $signed(a) < $signed(b) ##1 ok |=> trap_req
      && trap_kind == KIND_LT;
  endproperty
  a_lt: assert property (p_lt) else $error("signed reg trap missing");

  property p_ltu;
    take && sp && fn == 6'h33 && a < b ##1 ok |=> trap_req && trap_kind == KIND_LTU;
  endproperty
  a_ltu: assert property (p_ltu) else $error("unsigned reg trap missing");

  property p_ne;
    take && sp && fn == FN_NE && a != b ##1 ok |=> trap_req && trap_kind == KIND_NE;
  endproperty
  a_ne: assert property (p_ne) else $error("reg not-equal trap missing");

  property p_lti;
    take && ri && sel == 5'h0a && $signed(a) < $signed(imm) ##1 ok |=> trap_req
      && trap_kind == KIND_LTI;
  endproperty
  a_lti: assert property (p_lti) else $error("imm trap missing");

  property p_ltiu;
    take && ri && sel == 5'h0b && a < imm ##1 ok |=> trap_req && trap_kind == KIND_LTIU;
  endproperty
  a_ltiu: assert property (p_ltiu) else $error("unsigned imm trap missing");

  property p_nei;
    take && ri && sel == 5'h0e && a != imm ##1 ok |=> trap_req && trap_kind == KIND_NEI;
  endproperty
  a_nei: assert property (p_nei) else $error("imm not-equal trap missing");

  property p_quiet;
    take && !hit ##1 ok |=> done && !trap_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("false condition trapped");

  property p_word;
    take && hit ##1 ok |=> trap_instr == $past(w, 2);
  endproperty
  a_word: assert property (p_word) else $error("trap word altered");

  property p_release;
    trap_req && exc_ack && ok |=> !trap_req && done ##1 !done;
  endproperty
  a_release: assert property (p_release) else $error("ack not honoured");

  // Main scenarios reached
  c_trap: cover property (trap_req && exc_ack);
  c_quiet: cover property (take && !hit);
  c_slow: cover property (trap_req [*4]);
endmodule

bind cdtu_trap_unit cdtu_trap_checker #(.XLEN(XLEN), .FN_LT(FN_LT), .FN_NE(FN_NE)) u_chk (
  .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .issue_valid(issue_valid),
  .issue_req(issue_req), .flush(flush), .exc_ack(exc_ack), .issue_ready(issue_ready),
  .done(done), .trap_req(trap_req), .trap_kind(trap_kind), .trap_instr(trap_instr));

// ### tb/tb.sv
// Testbench for the conditional trap unit
`timescale 1ns/100ps
module tb;
  import cdtu_pkg::*;
  logic mclk, reset_n, clk_en, issue_valid, flush, exc_ack;
  logic issue_ready, done, claimed, trap_req;
  cdtu_issue_t issue_req;
  cdtu_kind_t trap_kind;
  logic [63:0] trap_pc, pc;
  logic [31:0] trap_instr;
  logic [15:0] trap_count;
  logic [3:0] ack_delay;
  int n_mismatch, samples_checked, n_traps;

  cdtu_trap_unit DUT (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .issue_valid(issue_valid), .issue_req(issue_req), .flush(flush), .exc_ack(exc_ack),
    .issue_ready(issue_ready), .done(done), .claimed(claimed), .trap_req(trap_req),
    .trap_kind(trap_kind), .trap_pc(trap_pc), .trap_instr(trap_instr),
    .trap_count(trap_count));
  cdtu_exc_model PEER (.mclk(mclk), .reset_n(reset_n), .trap_req(trap_req),
    .ack_delay(ack_delay), .exc_ack(exc_ack));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task print_verdict;
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // Register and immediate instruction words
  function logic [31:0] rw(input logic [5:0] fn, input logic [9:0] code);
    return {6'h00, 5'h01, 5'h02, code, fn};
  endfunction
  function logic [31:0] iw(input logic [4:0] sel, input logic [15:0] imm);
    return {6'h01, 5'h03, sel, imm};
  endfunction

  // Issue one word, judge the answer and any trap handshake
  task op(input logic [31:0] w, input logic [63:0] a, b, input logic t, c,
          input cdtu_kind_t k);
    int n;
    @(posedge mclk);
    pc = pc + 64'h4;
    issue_req <= '{w, pc, a, b};
    issue_valid <= 1'b1;
    @(posedge mclk);
    issue_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (!(done || trap_req) && n < 9);
    chk(n == 1 && trap_req === t && done === !t, "answer");
    chk(claimed === c, "claimed");
    if (t) begin
      n_traps++;
      chk(trap_kind === k && trap_instr === w && trap_pc === pc, "trap record");
      chk(trap_count === 16'(n_traps), "trap count");
      n = 0;
      do begin
        @(posedge mclk);
        #1;
        n++;
      end while (done !== 1'b1 && n < 20);
      chk(done === 1'b1 && trap_req === 1'b0, "release");
    end
  endtask

  task t_reg_lt;
    op(rw(6'h32, 10'h3ff), '1, 64'h1, 1, 1, KIND_LT);
    op(rw(6'h32, 10'h000), 64'h1, '1, 0, 1, KIND_NONE);
    op(rw(6'h33, 10'h155), '1, 64'h1, 0, 1, KIND_NONE);
    op(rw(6'h33, 10'h2aa), 64'h1, '1, 1, 1, KIND_LTU);
  endtask

  task t_reg_ne;
    op(rw(6'h36, 10'h000), 64'h8000000000000000, 64'h0, 1, 1, KIND_NE);
    op(rw(6'h36, 10'h3ff), 64'h5, 64'h5, 0, 1, KIND_NONE);
  endtask

  task t_imm;
    op(iw(5'h0a, 16'hffff), 64'hfffffffffffffffe, 64'h0, 1, 1, KIND_LTI);
    op(iw(5'h0a, 16'hffff), 64'h0, 64'h0, 0, 1, KIND_NONE);
    op(iw(5'h0b, 16'h8000), 64'h7fff, 64'h0, 1, 1, KIND_LTIU);
    op(iw(5'h0b, 16'hffff), '1, 64'h0, 0, 1, KIND_NONE);
    op(iw(5'h0b, 16'h7fff), 64'h7fff, 64'h0, 0, 1, KIND_NONE);
    op(iw(5'h0e, 16'hffff), '1, 64'h0, 0, 1, KIND_NONE);
    op(iw(5'h0e, 16'hffff), 64'hffff, 64'h0, 1, 1, KIND_NEI);
  endtask

  task t_unclaimed;
    op(iw(5'h0c, 16'h0000), 64'h0, 64'h0, 0, 0, KIND_NONE);
    op(rw(6'h30, 10'h000), 64'h4, 64'h4, 0, 0, KIND_NONE);
    op({6'h02, 26'h0}, 64'h0, 64'h1, 0, 0, KIND_NONE);
  endtask

  task t_slow_ack;
    ack_delay <= 4'h5;
    op(rw(6'h32, 10'h001), 64'h2, 64'h3, 1, 1, KIND_LT);
    ack_delay <= 4'h0;
  endtask

  // Flush while a trap is pending drops it with no done
  task t_flush;
    ack_delay <= 4'h8;
    @(posedge mclk);
    pc = pc + 64'h4;
    issue_req <= '{rw(6'h36, 10'h000), pc, 64'h1, 64'h2};
    issue_valid <= 1'b1;
    @(posedge mclk);
    issue_valid <= 1'b0;
    @(posedge mclk);
    flush <= 1'b1;
    #1;
    n_traps++;
    chk(trap_req === 1'b1, "flush setup");
    @(posedge mclk);
    flush <= 1'b0;
    #1;
    chk(trap_req === 1'b0 && issue_ready === 1'b1 && done === 1'b0, "flush");
    chk(trap_count === 16'(n_traps), "flush count");
    ack_delay <= 4'h0;
    repeat (2) @(posedge mclk);
  endtask

  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    flush = 1'b0;
    issue_valid = 1'b0;
    issue_req = '0;
    ack_delay = 4'h0;
    pc = 64'h0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk(issue_ready === 1'b1 && trap_req === 1'b0 && trap_count === 16'h0000, "reset");
    t_reg_lt;
    t_reg_ne;
    t_imm;
    t_unclaimed;
    t_slow_ack;
    t_flush;
    print_verdict;
  end

  // Cuts a hung run short
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
endmodule
